// ===== rtl/agsc_regfile.sv
/*
  Four-entry register store with registered read data.
  Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none
`include "agsc_defines.svh"

module agsc_regfile (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       wr_en,
  input  wire logic [1:0] wr_addr,
  input  wire logic [7:0] wr_data,
  input  wire logic [1:0] rd_addr,
  output var  logic [7:0] rd_data,
  output var  logic [7:0] power_q,
  output var  logic [7:0] gain_q
);
  import agsc_pkg::*;

  typedef struct packed {
    logic [7:0] power_control;
    logic [7:0] gain_attenuation;
    logic [7:0] rd_data;
  } agsc_rf_s;

  agsc_rf_s st_ff;
  agsc_rf_s nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (wr_en && wr_addr == `AGSC_ADDR_POWER) begin
      nxt_st.power_control = wr_data;
    end else if (wr_en && wr_addr == `AGSC_ADDR_GAIN) begin
      nxt_st.gain_attenuation = wr_data;
    end
    if (rd_addr == `AGSC_ADDR_REVISION) begin
      nxt_st.rd_data = `AGSC_REVISION_VALUE; // R22
    end else if (rd_addr == `AGSC_ADDR_PART) begin
      nxt_st.rd_data = `AGSC_PART_VALUE; // R22
    end else if (rd_addr == `AGSC_ADDR_POWER) begin
      nxt_st.rd_data = st_ff.power_control;
    end else begin
      nxt_st.rd_data = st_ff.gain_attenuation;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_ff <= '{`AGSC_POWER_RESET, `AGSC_GAIN_RESET, 8'h00};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rd_data = st_ff.rd_data;
  assign power_q = st_ff.power_control;
  assign gain_q  = st_ff.gain_attenuation;
endmodule : agsc_regfile

`default_nettype wire

// ===== rtl/agsc_serial_port.sv
/*
  Serial control port of a programmable-gain amplifier: 16-bit frames,
  register access, gain and shutdown outputs.
  Assumes the link pins and mode pin are asynchronous to clock and that
  the serial clock is far slower than clock (bench period 160 ns).
*/
// How it works
// R1: Serial port works only with mode pin high.
// R2: Enable inputs ignored in serial mode.
// R3: Input bits sampled on serial clock rise.
// R4: Output bits launched on serial clock fall.
// R5: Host may park serial clock low.
// R6: Select falling restarts bit count at zero.
// R7: Early deselect: no address capture, no write; after eight bits the read pointer already holds the frame address.
// R8: Select rise latches address, writes register.
// R9: Each frame holds exactly sixteen bits.
// R10: Output driven only while selected.
// R11: Addressed register shifted out, second byte.
// R12: Address pointer resets to zero.
// R13: Read bit one reads, zero writes.
// R14: Host sends reserved bit as zero.
// R15: Read frames change no register.
// R16: Power bit 2 is shutdown; zero on.
// R17: Gain low seven bits, counts 0..80; register values above 80 pass to the gain output unclamped.
// R18: Shutdown keeps last gain setting.
// R19: Mode low: shared pins are gain bits.
// R20: Serial mode ignores shutdown pin.
// R21: Most significant bit first, command then data.
// R22: Identification registers ignore writes.
`timescale 1ns/10ps
`default_nettype none
`include "agsc_defines.svh"

module agsc_serial_port (
  input  wire logic               clock,
  input  wire logic               sys_rst,
  input  wire logic               mode_serial_pin,
  input  wire agsc_pkg::agsc_link_s link_in,
  input  wire agsc_pkg::agsc_par_s  par_in,
  input  wire logic [1:0]         enable_pins,
  output var  logic               serial_out,
  output var  logic               serial_out_oe,
  output var  logic [6:0]         gain_setting,
  output var  logic               amp_shutdown,
  output var  logic               serial_active
);
  import agsc_pkg::*;

  typedef struct packed {
    logic [1:0]  mode_sync;
    logic [1:0]  clk_sync;
    logic [1:0]  cs_sync;
    logic [1:0]  din_sync;
    logic [9:0]  par_sync1;
    logic [9:0]  par_sync2;
    logic        clk_prev;
    logic        cs_prev;
    agsc_state_e state;
    logic [4:0]  bit_cnt;
    logic [15:0] shift_in;
    logic [1:0]  addr_ptr;
    logic [7:0]  shift_out;
    logic        dout;
    logic        dout_oe;
    logic [6:0]  gain;
    logic        shutdown;
    logic        active;
  } agsc_top_s;

  agsc_top_s  st_ff;
  agsc_top_s  nxt_st;
  logic       wr_en;
  logic [1:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic [7:0] power_q;
  logic [7:0] gain_q;

  function automatic logic [1:0] frame_addr(input logic [15:0] f);
    frame_addr = f[`AGSC_ADDR_LSB+1:`AGSC_ADDR_LSB];
  endfunction : frame_addr

  function automatic logic frame_complete(input logic [4:0] cnt);
    frame_complete = (cnt == `AGSC_FRAME_BITS);
  endfunction : frame_complete

  logic serial_mode;
  logic clk_rise;
  logic clk_fall;
  logic cs_fall;
  logic cs_rise;
  logic cs_low;
  logic [6:0] par_gain;

  always_comb begin
    serial_mode = st_ff.mode_sync[1];
    cs_low      = !st_ff.cs_sync[1] && serial_mode;
    clk_rise    = st_ff.clk_sync[1] && !st_ff.clk_prev;
    clk_fall    = !st_ff.clk_sync[1] && st_ff.clk_prev;
    cs_fall     = !st_ff.cs_sync[1] && st_ff.cs_prev;
    cs_rise     = st_ff.cs_sync[1] && !st_ff.cs_prev;
    // Parallel mode: four pins give 2 dB steps (8 counts per step)
    par_gain    = {st_ff.par_sync2[9:6], 3'b000}; // R19
    nxt_st = st_ff;
    wr_en   = 1'b0;
    wr_addr = frame_addr(st_ff.shift_in);
    wr_data = st_ff.shift_in[7:0];
    nxt_st.mode_sync = {st_ff.mode_sync[0], mode_serial_pin};
    nxt_st.clk_sync  = {st_ff.clk_sync[0], link_in.serial_clk};
    nxt_st.cs_sync   = {st_ff.cs_sync[0], link_in.chip_select_n_pin};
    nxt_st.din_sync  = {st_ff.din_sync[0], link_in.serial_in};
    nxt_st.par_sync1 = {par_in.gain_bits, par_in.shutdown_pin, 5'h00};
    nxt_st.par_sync2 = st_ff.par_sync1;
    nxt_st.clk_prev  = st_ff.clk_sync[1];
    nxt_st.cs_prev   = st_ff.cs_sync[1];
    nxt_st.active    = serial_mode; // R1

    case (st_ff.state)
      AGSC_IDLE: begin
        if (cs_fall && serial_mode) begin // R6
          nxt_st.state   = AGSC_SHIFT;
          nxt_st.bit_cnt = 5'h00; // R6
        end
      end
      AGSC_SHIFT: begin
        if (!serial_mode) begin
          nxt_st.state = AGSC_IDLE;
        end else if (cs_rise) begin
          nxt_st.state = AGSC_IDLE;
          if (frame_complete(st_ff.bit_cnt)) begin // R7 R9
            nxt_st.addr_ptr = frame_addr(st_ff.shift_in); // R8
            wr_en = !st_ff.shift_in[`AGSC_RW_BIT]; // R8 R13 R15
          end
        end else if (clk_rise && !frame_complete(st_ff.bit_cnt)) begin // R3 R5
          nxt_st.shift_in = {st_ff.shift_in[14:0], st_ff.din_sync[1]}; // R21
          nxt_st.bit_cnt  = st_ff.bit_cnt + 5'h01;
          if (st_ff.bit_cnt == `AGSC_BYTE_BITS - 5'h01) begin
            // Low address bits: last bit held plus the one arriving now
            nxt_st.addr_ptr = {st_ff.shift_in[0], st_ff.din_sync[1]}; // R11
          end
        end else if (clk_fall && st_ff.bit_cnt == `AGSC_BYTE_BITS) begin
          nxt_st.shift_out = rd_data; // R11
          nxt_st.dout      = rd_data[7]; // R4 R21
          nxt_st.state     = AGSC_DONE;
        end
      end
      AGSC_DONE: begin
        if (!serial_mode) begin
          nxt_st.state = AGSC_IDLE;
        end else if (cs_rise) begin
          nxt_st.state = AGSC_IDLE;
          if (frame_complete(st_ff.bit_cnt)) begin // R7 R9
            nxt_st.addr_ptr = frame_addr(st_ff.shift_in); // R8
            wr_en = !st_ff.shift_in[`AGSC_RW_BIT]; // R13 R15
          end
        end else if (clk_rise && !frame_complete(st_ff.bit_cnt)) begin // R3
          nxt_st.shift_in = {st_ff.shift_in[14:0], st_ff.din_sync[1]};
          nxt_st.bit_cnt  = st_ff.bit_cnt + 5'h01;
        end else if (clk_fall && !frame_complete(st_ff.bit_cnt)) begin // R4 R11
          nxt_st.shift_out = {st_ff.shift_out[6:0], 1'b0};
          nxt_st.dout      = st_ff.shift_out[6];
        end
      end
      default: begin
        nxt_st.state = AGSC_IDLE;
      end
    endcase

    nxt_st.dout_oe = cs_low; // R10
    if (!cs_low) begin
      nxt_st.dout = 1'b0;
    end

    if (serial_mode) begin
      // Register bit 7 reserved; gain tracks register even in shutdown
      nxt_st.gain     = gain_q[6:0]; // R17 R18
      nxt_st.shutdown = power_q[`AGSC_SHUTDOWN_BIT]; // R16 R20 R2
    end else begin
      nxt_st.gain     = par_gain; // R19
      nxt_st.shutdown = st_ff.par_sync2[5];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_ff <= '{
        mode_sync: 2'h0, clk_sync: 2'h0, cs_sync: 2'h3, din_sync: 2'h0,
        par_sync1: 10'h000, par_sync2: 10'h000, clk_prev: 1'b0,
        cs_prev: 1'b1, state: AGSC_IDLE, bit_cnt: 5'h00,
        shift_in: 16'h0000, addr_ptr: 2'h0, shift_out: 8'h00, // R12
        dout: 1'b0, dout_oe: 1'b0, gain: 7'h50, shutdown: 1'b0,
        active: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  agsc_regfile u_regs (
    .clock   (clock),
    .sys_rst (sys_rst),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .rd_addr (st_ff.addr_ptr),
    .rd_data (rd_data),
    .power_q (power_q),
    .gain_q  (gain_q)
  );

  assign serial_out    = st_ff.dout;
  assign serial_out_oe = st_ff.dout_oe;
  assign gain_setting  = st_ff.gain;
  assign amp_shutdown  = st_ff.shutdown;
  assign serial_active = st_ff.active;
endmodule : agsc_serial_port

`default_nettype wire

// ===== shared/agsc_defines.svh
/*
  Offsets, field positions, reset values and frame counts of the serial
  gain-control port. Assumes nothing; definitions only.
*/
`ifndef AGSC_DEFINES_SVH
`define AGSC_DEFINES_SVH

`define AGSC_ADDR_REVISION   2'h0
`define AGSC_ADDR_PART       2'h1
`define AGSC_ADDR_POWER      2'h2
`define AGSC_ADDR_GAIN       2'h3
// Identification values are arbitrary
`define AGSC_REVISION_VALUE  8'hA5
`define AGSC_PART_VALUE      8'h5A
`define AGSC_POWER_RESET     8'h00
`define AGSC_GAIN_RESET      8'h50
`define AGSC_SHUTDOWN_BIT    2
`define AGSC_GAIN_MASK       8'h7F
`define AGSC_GAIN_MAX        7'h50
`define AGSC_FRAME_BITS      5'h10
`define AGSC_BYTE_BITS       5'h08
`define AGSC_RW_BIT          15
`define AGSC_ADDR_MSB        13
`define AGSC_ADDR_LSB        8

`endif

// ===== shared/agsc_pkg.sv
/*
  Types of the serial gain-control port.
  Assumes agsc_defines.svh is on the include path.
*/
`default_nettype none
package agsc_pkg;

  typedef struct packed {
    logic serial_in;
    logic serial_clk;
    logic chip_select_n_pin;
  } agsc_link_s;

  typedef struct packed {
    logic [3:0] gain_bits;
    logic       shutdown_pin;
  } agsc_par_s;

  typedef enum logic [1:0] {
    AGSC_IDLE  = 2'b00,
    AGSC_SHIFT = 2'b01,
    AGSC_DONE  = 2'b10
  } agsc_state_e;

endpackage : agsc_pkg

`default_nettype wire

// ===== sim/agsc_host.sv
/*
  Serial host model: sends the first n bits of a 16-bit frame, collects read data.
  Assumes data out is resolved with its pull-up by the caller, and the
  bench clock; serial clock half period is eight bench clocks.
*/
`timescale 1ns/10ps
`default_nettype none
module agsc_host (
  input  wire logic                clock,
  output var agsc_pkg::agsc_link_s link,
  input  wire logic                sdo_wire
);
  import agsc_pkg::*;
  initial link = 3'b101; // Clock parked low, deselected
  task automatic xfer(input logic [15:0] w, input int n, output logic [7:0] rd);
    int i;
    rd = 8'h00;
    @(posedge clock) link.chip_select_n_pin <= 1'b0;
    for (i = 0; i < n; i++) begin
      link.serial_in <= w[15 - i];
      repeat (8) @(posedge clock);
      link.serial_clk <= 1'b1;
      if (i >= 8) rd = {rd[6:0], sdo_wire};
      repeat (8) @(posedge clock);
      link.serial_clk <= 1'b0;
    end
    repeat (8) @(posedge clock);
    link.chip_select_n_pin <= 1'b1;
    link.serial_in <= ~link.serial_in;
    repeat (40) @(posedge clock);
  endtask : xfer
endmodule : agsc_host
`default_nettype wire

// ===== sim/agsc_properties.sv
/*
  Pin-level assertions of the serial gain-control port.
  Assumes binding to agsc_serial_port, one clock, sync reset.
*/
`timescale 1ns/10ps
`default_nettype none
module agsc_props (
  input wire logic                  clock,
  input wire logic                  sys_rst,
  input wire logic                  mode_serial_pin,
  input wire agsc_pkg::agsc_link_s  link_in,
  input wire agsc_pkg::agsc_par_s   par_in,
  input wire logic [1:0]            enable_pins,
  input wire logic                  serial_out,
  input wire logic                  serial_out_oe,
  input wire logic [6:0]            gain_setting,
  input wire logic                  amp_shutdown,
  input wire logic                  serial_active
);
  import agsc_pkg::*;
  logic       cs_n;
  logic       cs_ff;
  logic [3:0] quiet_ff;
  assign cs_n = link_in.chip_select_n_pin;
  // Cycles since the last select edge, saturating
  always_ff @(posedge clock) begin
    cs_ff    <= cs_n;
    quiet_ff <= (sys_rst || cs_ff != cs_n) ? 4'h0 : quiet_ff + {3'h0, quiet_ff != 4'hF};
  end
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  property p_oe_off; cs_n[*5] |-> !serial_out_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("output driven while deselected");
  property p_oe_on; (serial_active && !cs_n)[*6] |-> serial_out_oe; endproperty
  a_oe_on: assert property (p_oe_on) else $error("output not driven while selected");
  property p_out_zero; !serial_out_oe |-> !serial_out; endproperty
  a_out_zero: assert property (p_out_zero) else $error("data out not parked");
  property p_mode_off; (!mode_serial_pin)[*5] |-> !serial_active; endproperty
  a_mode_off: assert property (p_mode_off) else $error("serial mode with pin low");
  property p_mode_on; mode_serial_pin[*5] |-> serial_active; endproperty
  a_mode_on: assert property (p_mode_on) else $error("serial mode missing");
  property p_par;
    (!mode_serial_pin && $stable(par_in))[*6] |->
      gain_setting[6:3] == par_in.gain_bits && amp_shutdown == par_in.shutdown_pin;
  endproperty
  a_par: assert property (p_par) else $error("parallel pins not applied");
  property p_quiet;
    (serial_active && mode_serial_pin && quiet_ff == 4'hF)[*8] |=>
      $stable(gain_setting) && $stable(amp_shutdown);
  endproperty
  a_quiet: assert property (p_quiet) else $error("setting changed without frame");
  property p_sd_keep; serial_active[*8] ##0 $changed(amp_shutdown) |-> $stable(gain_setting);
  endproperty
  a_sd_keep: assert property (p_sd_keep) else $error("gain lost at shutdown");
  c_read: cover property (serial_active && $fell(serial_out_oe));
  c_sd: cover property (serial_active && $rose(amp_shutdown));
  c_par: cover property (!serial_active && amp_shutdown);
endmodule : agsc_props
bind agsc_serial_port agsc_props u_props (.clock, .sys_rst, .mode_serial_pin, .link_in,
  .par_in, .enable_pins, .serial_out, .serial_out_oe, .gain_setting, .amp_shutdown,
  .serial_active);
`default_nettype wire

// ===== sim/amp_gain_serial_control_tb_top.sv
/*
  Self-checking bench of the serial gain-control port.
  Assumes agsc_defines.svh on the include path.
*/
`timescale 1ns/10ps
`default_nettype none
`include "agsc_defines.svh"
module amp_gain_serial_control_tb_top;
  import agsc_pkg::*;
  logic       clock = 1'b0;
  logic       sys_rst = 1'b1;
  logic       mode_serial_pin = 1'b1;
  agsc_par_s  par_in = 5'b1001_1;
  logic [1:0] enable_pins = 2'h0;
  agsc_link_s link_in;
  logic       serial_out, serial_out_oe, amp_shutdown, serial_active, sdo_wire;
  logic [6:0] gain_setting;
  logic [7:0] rd;
  int         failures = 0;
  int         comparisons = 0;
  assign sdo_wire = serial_out_oe ? serial_out : 1'b1;
  agsc_serial_port DUT (.clock, .sys_rst, .mode_serial_pin, .link_in, .par_in,
    .enable_pins, .serial_out, .serial_out_oe, .gain_setting, .amp_shutdown, .serial_active);
  agsc_host u_host (.clock(clock), .link(link_in), .sdo_wire(sdo_wire));
  initial begin
    forever #5 clock = ~clock;
  end
  task cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : cmp
  task wr(input logic [1:0] a, input logic [7:0] d, input int n);
    u_host.xfer({6'h00, a, d}, n, rd);
  endtask : wr
  task rdchk(input logic [1:0] a, input logic [7:0] exp);
    u_host.xfer({6'h20, a, 8'hFF}, 16, rd);
    cmp("read data", exp, rd);
  endtask : rdchk
  task t_reset;
    cmp("gain", `AGSC_GAIN_RESET, {1'b0, gain_setting});
    cmp("shutdown", 8'h00, {7'h00, amp_shutdown});
    rdchk(`AGSC_ADDR_REVISION, `AGSC_REVISION_VALUE);
    rdchk(`AGSC_ADDR_PART, `AGSC_PART_VALUE);
    rdchk(`AGSC_ADDR_POWER, `AGSC_POWER_RESET);
    rdchk(`AGSC_ADDR_GAIN, `AGSC_GAIN_RESET);
  endtask : t_reset
  task t_gain;
    wr(`AGSC_ADDR_GAIN, 8'h20, 16);
    cmp("gain", 8'h20, {1'b0, gain_setting});
    rdchk(`AGSC_ADDR_GAIN, 8'h20);
    cmp("gain", 8'h20, {1'b0, gain_setting});
  endtask : t_gain
  task t_power;
    wr(`AGSC_ADDR_POWER, 8'h04, 16);
    cmp("shutdown", 8'h01, {7'h00, amp_shutdown});
    cmp("gain", 8'h20, {1'b0, gain_setting});
    rdchk(`AGSC_ADDR_POWER, 8'h04);
    wr(`AGSC_ADDR_POWER, 8'h00, 16);
    cmp("shutdown", 8'h00, {7'h00, amp_shutdown});
  endtask : t_power
  task t_ident;
    wr(`AGSC_ADDR_REVISION, 8'h00, 16);
    wr(`AGSC_ADDR_PART, 8'hFF, 16);
    rdchk(`AGSC_ADDR_REVISION, `AGSC_REVISION_VALUE);
    rdchk(`AGSC_ADDR_PART, `AGSC_PART_VALUE);
  endtask : t_ident
  task t_short;
    @(posedge clock) enable_pins <= 2'h3;
    wr(`AGSC_ADDR_GAIN, 8'h11, 15);
    cmp("gain", 8'h20, {1'b0, gain_setting});
    wr(`AGSC_ADDR_GAIN, 8'h50, 16);
    cmp("gain", 8'h50, {1'b0, gain_setting});
  endtask : t_short
  task t_parallel;
    @(posedge clock) mode_serial_pin <= 1'b0;
    repeat (20) @(posedge clock);
    cmp("active", 8'h00, {7'h00, serial_active});
    cmp("par gain", 8'h09, {4'h0, gain_setting[6:3]});
    cmp("shutdown", 8'h01, {7'h00, amp_shutdown});
    wr(`AGSC_ADDR_GAIN, 8'h10, 16);
    @(posedge clock) mode_serial_pin <= 1'b1;
    repeat (20) @(posedge clock);
    cmp("gain", 8'h50, {1'b0, gain_setting});
    cmp("shutdown", 8'h00, {7'h00, amp_shutdown});
  endtask : t_parallel
  task finish_test;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  initial begin
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (10) @(posedge clock);
    t_reset();
    t_gain();
    t_power();
    t_ident();
    t_short();
    t_parallel();
    finish_test();
  end
  initial begin
    #200000;
    failures++;
    finish_test();
  end
endmodule : amp_gain_serial_control_tb_top
`default_nettype wire
